// ---- include/timer_pkg.sv ----
// Shared constants, modes and configuration carriers for the capture/compare timer.
// Assumes configuration words are held stable by the surrounding logic while the timer runs.
package timer_pkg;

   localparam int CH_N    = 4;
   localparam int PAIR_N  = 3;
   localparam int PSC_W   = 16;
   localparam int DEAD_W  = 8;
   localparam int SYNC_N  = 6;

   // Bit positions in the synchroniser vector and the flag-clear vector
   localparam int EXT_TRIG_IDX = 4;
   localparam int CHAIN_IDX    = 5;
   localparam int UPD_CLR_IDX  = 4;

   // Reset values
   localparam logic [PSC_W-1:0]  PSC_RST  = 16'h0000;
   localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
   localparam logic [1:0]        QUAD_RST = 2'h0;

   typedef enum logic [2:0] {
      CH_OFF,
      CH_CAPTURE,
      CH_COMPARE,
      CH_PWM,
      CH_ONE_PULSE
   } ch_mode_t;

   typedef enum logic [1:0] {
      CNT_EDGE,
      CNT_CENTER,
      CNT_ENCODER
   } cnt_mode_t;

   typedef enum logic [1:0] {
      SLV_OFF,
      SLV_RESET,
      SLV_GATED,
      SLV_TRIGGER
   } slave_mode_t;

   typedef struct packed {
      logic              enable;
      logic              dir_down;
      cnt_mode_t         cnt_mode;
      slave_mode_t       slave_mode;
      logic              trig_chain;
      logic [PSC_W-1:0]  psc;
      logic [31:0]       arr;
      logic [DEAD_W-1:0] dead;
   } timer_cfg_t;

   typedef struct packed {
      ch_mode_t    mode;
      logic        cap_falling;
      logic        cross_in;
      logic        invert;
      logic [31:0] ccr;
   } ch_cfg_t;

endpackage

// ---- rtl/quad_decoder.sv ----
// Quadrature decoder: two raw encoder pins in, one-cycle count steps out.
// Assumes raw pins are asynchronous to mclk; both are synchronised here.
`timescale 1ns/1ps
module quad_decoder (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic enc_a,
   input  wire logic enc_b,
   output logic      step,
   output logic      step_down
);
   logic [1:0] s1_reg;
   logic [1:0] s2_reg;
   logic [1:0] prev_reg;
   logic       step_reg;
   logic       down_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg   <= timer_pkg::QUAD_RST;
         s2_reg   <= timer_pkg::QUAD_RST;
         prev_reg <= timer_pkg::QUAD_RST;
      end else begin
         s1_reg   <= {enc_a, enc_b};
         s2_reg   <= s1_reg;
         prev_reg <= s2_reg;
      end
   end

   // Both bits moving at once is a lost edge; dropped rather than guessed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         step_reg <= 1'b0;
         down_reg <= 1'b0;
      end else begin
         step_reg <= (prev_reg != s2_reg) && ((prev_reg ^ s2_reg) != 2'b11); // [R07]
         // Direction only moves on a valid step, so a resting shaft keeps its sense
         if ((prev_reg != s2_reg) && ((prev_reg ^ s2_reg) != 2'b11)) begin
            down_reg <= prev_reg[1] ^ s2_reg[0]; // [R07]
         end
      end
   end

   assign step      = step_reg;
   assign step_down = down_reg;

   quad_fwd_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R07]
      $rose(s2_reg[1]) && !s2_reg[0] && $stable(s2_reg[0]) |=> step_reg && !down_reg)
      else $error("Forward quadrature edge not counted up");
endmodule

// ---- rtl/dead_time.sv ----
// One complementary output pair with a blanking gap after every reference change.
// Assumes the gap length is held stable while a gap is being timed.
`timescale 1ns/1ps
module dead_time (
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic                        ref_lvl,
   input  wire logic [timer_pkg::DEAD_W-1:0] dead,
   output logic                             out_hi,
   output logic                             out_lo
);
   logic                        ref_prev_reg;
   logic [timer_pkg::DEAD_W-1:0] gap_reg;
   logic                        hi_reg;
   logic                        lo_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev_reg <= 1'b0;
         gap_reg      <= timer_pkg::DEAD_RST;
         hi_reg       <= 1'b0;
         lo_reg       <= 1'b0;
      end else if (ref_lvl != ref_prev_reg) begin
         ref_prev_reg <= ref_lvl;
         gap_reg      <= dead;
         hi_reg       <= (dead == 8'h00) & ref_lvl;  // [R05]
         lo_reg       <= (dead == 8'h00) & ~ref_lvl; // [R05]
      end else if (gap_reg > 8'h01) begin
         gap_reg <= gap_reg - 8'h01;
      end else begin
         gap_reg <= 8'h00;
         hi_reg  <= ref_prev_reg;
         lo_reg  <= ~ref_prev_reg;
      end
   end

   assign out_hi = hi_reg;
   assign out_lo = lo_reg;

   no_overlap_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R05]
      !(hi_reg && lo_reg))
      else $error("Both sides of a pair driven together");

   dead_gap_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R05]
      $rose(hi_reg) && $stable(dead) && dead != 8'h00 |-> !$past(lo_reg))
      else $error("High side asserted with no dead gap");
endmodule

// ---- rtl/cc_timer.sv ----
// Capture/compare/PWM timer with prescaler, encoder input, slave trigger and dead time.
// Assumes configuration comes from logic on mclk; every pin input is asynchronous.
// How it works
// (R01) 16-bit up/down counter, prescaled, auto-reloaded
// (R02) Counter width is a build parameter
// (R03) Build option removes down-counting
// (R04) Four channels: capture, compare, PWM, one-pulse
// (R05) Complementary outputs with programmable dead time
// (R06) Three complementary pairs for three-phase drive
// (R07) Quadrature encoder steers counter up or down
// (R08) External trigger input is accepted
// (R09) Slave synchronisation and trigger chaining between timers
// (R10) Capture channels measure input pulse width
// (R11) Wrap reloads counter and flags update
// (R12) Match or capture sets sticky channel flag
`timescale 1ns/1ps
module cc_timer #(
   parameter int CNT_W   = 16,  // [R02]
   parameter bit UP_ONLY = 1'b0 // [R03]
)(
   input  wire logic                                    mclk,
   input  wire logic                                    rst_b,
   input  wire timer_pkg::timer_cfg_t                   cfg,
   input  wire timer_pkg::ch_cfg_t [timer_pkg::CH_N-1:0] ch_cfg,
   input  wire logic [timer_pkg::CH_N:0]                flag_clr,
   input  wire logic [timer_pkg::CH_N-1:0]              ch_in,
   input  wire logic                                    enc_a,
   input  wire logic                                    enc_b,
   input  wire logic                                    ext_trig,
   input  wire logic                                    chain_trig_in,
   output logic [timer_pkg::CH_N-1:0]                   ch_out,
   output logic [timer_pkg::PAIR_N-1:0]                 pwm_hi,
   output logic [timer_pkg::PAIR_N-1:0]                 pwm_lo,
   output logic [CNT_W-1:0]                             count,
   output logic                                         count_down,
   output logic                                         upd_flag,
   output logic [timer_pkg::CH_N-1:0]                   ch_flag,
   output logic [timer_pkg::CH_N-1:0][CNT_W-1:0]        cap_val,
   output logic                                         trig_out
);
   logic [timer_pkg::SYNC_N-1:0] sync1_reg;
   logic [timer_pkg::SYNC_N-1:0] sync2_reg;
   logic                         trig_prev_reg;
   logic                         en_prev_reg;
   logic                         run_reg;
   logic                         dir_reg;
   logic                         dir_out_reg;
   logic                         upd_flag_reg;
   logic                         trig_out_reg;
   logic [timer_pkg::PSC_W-1:0]  psc_cnt_reg;
   logic [CNT_W-1:0]             cnt_reg;
   logic [CNT_W-1:0]             cnt_next;
   logic [CNT_W-1:0]             arr;
   logic [timer_pkg::CH_N-1:0]   op_vec;
   logic                         trig_lvl;
   logic                         trig_rise;
   logic                         slv_rst;
   logic                         gate_ok;
   logic                         enc_mode;
   logic                         center;
   logic                         going_down;
   logic                         psc_tick;
   logic                         step_ok;
   logic                         update;
   logic                         at_top;
   logic                         at_zero;
   logic                         enc_step;
   logic                         enc_down;

   // Every pin passes two flops; only the second stage is looked at
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {chain_trig_in, ext_trig, ch_in}; // [R08]
         sync2_reg <= sync1_reg;
      end
   end

   quad_decoder u_quad (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .enc_a     (enc_a),
      .enc_b     (enc_b),
      .step      (enc_step),
      .step_down (enc_down)
   );

   // Trigger source: own pin or a neighbouring timer's update output
   assign trig_lvl  = cfg.trig_chain ? sync2_reg[timer_pkg::CHAIN_IDX]
                                     : sync2_reg[timer_pkg::EXT_TRIG_IDX]; // [R08] [R09]
   assign trig_rise = trig_lvl & ~trig_prev_reg;
   assign slv_rst   = (cfg.slave_mode == timer_pkg::SLV_RESET) && trig_rise; // [R09]
   assign gate_ok   = (cfg.slave_mode != timer_pkg::SLV_GATED) || trig_lvl; // [R09]
   assign enc_mode  = (cfg.cnt_mode == timer_pkg::CNT_ENCODER);
   assign center    = (cfg.cnt_mode == timer_pkg::CNT_CENTER) && !UP_ONLY;
   assign arr       = cfg.arr[CNT_W-1:0];
   assign at_top    = (cnt_reg >= arr);
   assign at_zero   = (cnt_reg == '0);

   always_comb begin
      unique case (cfg.cnt_mode)
         timer_pkg::CNT_EDGE:    going_down = cfg.dir_down && !UP_ONLY; // [R01] [R03]
         timer_pkg::CNT_CENTER:  going_down = dir_reg;
         timer_pkg::CNT_ENCODER: going_down = enc_down;                 // [R07]
         default:                going_down = 1'b0;
      endcase
   end

   // Encoder steps bypass the prescaler; they already are the count clock
   assign psc_tick = run_reg && gate_ok && !enc_mode && (psc_cnt_reg == cfg.psc); // [R01]
   assign step_ok  = (enc_mode ? (run_reg && gate_ok && enc_step) : psc_tick)
                     && !(UP_ONLY && going_down); // [R03] [R07]

   always_comb begin
      cnt_next = cnt_reg;
      update   = 1'b0;
      if (slv_rst) begin
         cnt_next = going_down ? arr : '0; // [R09]
      end else if (step_ok && going_down) begin
         if (at_zero) begin
            update   = 1'b1; // [R11]
            cnt_next = center ? ((arr == '0) ? '0 : CNT_W'(1)) : arr;
         end else begin
            cnt_next = cnt_reg - CNT_W'(1);
         end
      end else if (step_ok) begin
         if (at_top) begin
            update   = 1'b1; // [R11]
            cnt_next = center ? ((arr == '0) ? '0 : arr - CNT_W'(1)) : '0;
         end else begin
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg     <= '0;
         dir_out_reg <= 1'b0;
      end else begin
         cnt_reg     <= cnt_next; // [R01] [R11]
         dir_out_reg <= going_down;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         psc_cnt_reg <= timer_pkg::PSC_RST;
      end else if (!run_reg || slv_rst) begin
         psc_cnt_reg <= timer_pkg::PSC_RST;
      end else if (gate_ok) begin
         psc_cnt_reg <= psc_tick ? timer_pkg::PSC_RST : psc_cnt_reg + 16'h0001; // [R01]
      end
   end

   // Center mode turns round at each end of the range
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dir_reg <= 1'b0;
      end else if (!center) begin
         dir_reg <= 1'b0;
      end else if (update) begin
         dir_reg <= ~dir_reg; // [R04]
      end
   end

   // One-pulse mode stops the counter at its update; a new start needs an
   // enable edge or a trigger, so the pulse is never repeated by itself
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         run_reg       <= 1'b0;
         en_prev_reg   <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         en_prev_reg   <= cfg.enable;
         trig_prev_reg <= trig_lvl;
         if (!cfg.enable || ((|op_vec) && update)) begin
            run_reg <= 1'b0; // [R04]
         end else if (!en_prev_reg ||
                      (cfg.slave_mode == timer_pkg::SLV_TRIGGER && trig_rise)) begin
            run_reg <= 1'b1; // [R09]
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         upd_flag_reg <= 1'b0;
         trig_out_reg <= 1'b0;
      end else begin
         trig_out_reg <= update; // [R09]
         if (update) begin
            upd_flag_reg <= 1'b1; // [R11]
         end else if (flag_clr[timer_pkg::UPD_CLR_IDX]) begin
            upd_flag_reg <= 1'b0;
         end
      end
   end

   for (genvar i = 0; i < timer_pkg::CH_N; i++) begin : g_ch
      timer_pkg::ch_cfg_t cc;
      logic               lvl;
      logic               edge_hit;
      logic               match;
      logic               prev_reg;
      logic               flag_reg;
      logic               tog_reg;
      logic               out_reg;
      logic [CNT_W-1:0]   cmp;
      logic [CNT_W-1:0]   cap_reg;

      assign cc  = ch_cfg[i];
      assign cmp = cc.ccr[CNT_W-1:0];
      // Cross input lets two channels see one pin: one edge each gives a width
      assign lvl      = cc.cross_in ? sync2_reg[i ^ 1] : sync2_reg[i]; // [R10]
      assign edge_hit = cc.cap_falling ? (prev_reg & ~lvl) : (~prev_reg & lvl);
      assign match    = step_ok && !slv_rst && (cnt_next == cmp);
      assign op_vec[i] = (cc.mode == timer_pkg::CH_ONE_PULSE);

      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            prev_reg <= 1'b0;
            cap_reg  <= '0;
         end else begin
            prev_reg <= lvl;
            if (cc.mode == timer_pkg::CH_CAPTURE && edge_hit) begin
               cap_reg <= cnt_reg; // [R04] [R10]
            end
         end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            flag_reg <= 1'b0;
         end else if ((cc.mode == timer_pkg::CH_CAPTURE) ? edge_hit
                      : (cc.mode != timer_pkg::CH_OFF && match)) begin
            flag_reg <= 1'b1; // [R12]
         end else if (flag_clr[i]) begin
            flag_reg <= 1'b0;
         end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            tog_reg <= 1'b0;
            out_reg <= 1'b0;
         end else begin
            tog_reg <= (cc.mode == timer_pkg::CH_COMPARE) && (tog_reg ^ match);
            unique case (cc.mode)
               timer_pkg::CH_OFF,
               timer_pkg::CH_CAPTURE:   out_reg <= 1'b0;
               timer_pkg::CH_COMPARE:   out_reg <= (tog_reg ^ match) ^ cc.invert; // [R04]
               timer_pkg::CH_PWM:       out_reg <= (cnt_next < cmp) ^ cc.invert;  // [R04]
               timer_pkg::CH_ONE_PULSE:
                  out_reg <= (run_reg && !update && cnt_next >= cmp) ^ cc.invert; // [R04]
               default:                 out_reg <= 1'b0;
            endcase
         end
      end

      assign ch_out[i]  = out_reg;
      assign ch_flag[i] = flag_reg;
      assign cap_val[i] = cap_reg;

      if (i < timer_pkg::PAIR_N) begin : g_pair
         dead_time u_dt (
            .mclk    (mclk),
            .rst_b   (rst_b),
            .ref_lvl (out_reg),
            .dead    (cfg.dead),
            .out_hi  (pwm_hi[i]),
            .out_lo  (pwm_lo[i])
         ); // [R06]
      end

      flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R12]
         flag_reg && !flag_clr[i] |=> flag_reg)
         else $error("Channel flag dropped without a clear");

      cap_value_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
         cc.mode == timer_pkg::CH_CAPTURE && edge_hit
         |=> cap_reg == $past(cnt_reg) && flag_reg)
         else $error("Capture did not latch the count");

      pwm_level_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R04]
         (cc.mode == timer_pkg::CH_PWM && !cc.invert)
         ##1 (cc.mode == timer_pkg::CH_PWM && !cc.invert && $stable(cmp))
         |-> out_reg == (cnt_reg < cmp))
         else $error("PWM level disagrees with counter");
   end

   assign count      = cnt_reg;
   assign count_down = dir_out_reg;
   assign upd_flag   = upd_flag_reg;
   assign trig_out   = trig_out_reg;

   upd_reload_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
      step_ok && !going_down && at_top && !center && !slv_rst
      |=> cnt_reg == '0 && upd_flag_reg && trig_out_reg)
      else $error("Up overflow did not wrap and flag");

   down_reload_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R01]
      step_ok && going_down && at_zero && !center && !slv_rst
      |=> cnt_reg == $past(arr) && upd_flag_reg)
      else $error("Down underflow did not reload");

   up_only_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R03]
      UP_ONLY && step_ok && !at_top && !slv_rst
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("Up-only counter did not step up");

   psc_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R01]
      !step_ok && !slv_rst |=> $stable(cnt_reg))
      else $error("Counter moved without a step");

   slave_reset_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R09]
      slv_rst && !going_down |=> cnt_reg == '0 && psc_cnt_reg == timer_pkg::PSC_RST)
      else $error("Slave reset did not clear counter");
endmodule

// ---- dv/pin_model.sv ----
// Pin-side partner: quadrature encoder shaft and a capture pulse source.
// Assumes the timer synchronises every pin itself; levels hold between calls.
`timescale 1ns/1ps
module pin_model (
   input  wire logic mclk,
   output logic      enc_a,
   output logic      enc_b,
   output logic [3:0] ch_pin
);
   logic [1:0] pos = 2'h0;

   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
      ch_pin = 4'h0;
   end

   // Gray position: one line changes per step; six cycles outlast the synchroniser
   task automatic quad(input int n, input bit back);
      for (int i = 0; i < n; i++) begin
         repeat (6) @(posedge mclk);
         pos = back ? pos - 2'h1 : pos + 2'h1;
         enc_a <= pos[0] ^ pos[1];
         enc_b <= pos[1];
      end
   endtask

   // Both lines at once is not a quadrature step and must be ignored
   task automatic jump();
      repeat (6) @(posedge mclk);
      pos = pos + 2'h2;
      enc_a <= pos[0] ^ pos[1];
      enc_b <= pos[1];
   endtask

   task automatic pulse(input int idx, input int width);
      @(posedge mclk);
      ch_pin[idx] <= 1'b1;
      repeat (width) @(posedge mclk);
      ch_pin[idx] <= 1'b0;
   endtask
endmodule

// ---- dv/test_cc_timer.sv ----
// Self-checking bench for cc_timer with a cycle model of the counter and channels.
// Assumes the 16-bit default build and pins driven by pin_model.
`timescale 1ns/1ps
module test_cc_timer;
   logic                                    mclk = 1'b0;
   logic                                    rst_b = 1'b0;
   timer_pkg::timer_cfg_t                   cfg = '0;
   timer_pkg::ch_cfg_t [timer_pkg::CH_N-1:0] ch_cfg = '0;
   logic [timer_pkg::CH_N:0]                flag_clr = '0;
   logic                                    ext_trig = 1'b0;
   logic                                    chain_trig_in = 1'b0;
   logic                                    enc_a;
   logic                                    enc_b;
   logic [3:0]                              ch_in;
   logic [3:0]                              ch_out;
   logic [2:0]                              pwm_hi;
   logic [2:0]                              pwm_lo;
   logic [15:0]                             count;
   logic                                    count_down;
   logic                                    upd_flag;
   logic [3:0]                              ch_flag;
   logic [3:0][15:0]                        cap_val;
   logic                                    trig_out;
   int                                      errors = 0;
   int                                      check_count = 0;
   int                                      m_cnt;
   int                                      m_pc;
   int                                      st [3];
   bit                                      m_run, m_en, m_upd, m_trig, m_o2, m_f2, wrap;
   bit                                      chk_on = 1'b0;
   logic [2:0]                              ref_q = 3'h0;

   always #12.5 mclk = ~mclk;

   pin_model i_pins (.mclk(mclk), .enc_a(enc_a), .enc_b(enc_b), .ch_pin(ch_in));

   cc_timer i_dut (
      .mclk(mclk), .rst_b(rst_b), .cfg(cfg), .ch_cfg(ch_cfg), .flag_clr(flag_clr),
      .ch_in(ch_in), .enc_a(enc_a), .enc_b(enc_b), .ext_trig(ext_trig),
      .chain_trig_in(chain_trig_in), .ch_out(ch_out), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo),
      .count(count), .count_down(count_down), .upd_flag(upd_flag), .ch_flag(ch_flag),
      .cap_val(cap_val), .trig_out(trig_out)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
   endtask

   // Reference: counter steps on the edge that ends a prescaler tick cycle
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {m_cnt, m_pc, m_run, m_en, m_upd, m_trig, m_o2, m_f2} = '0;
      end else begin
         m_trig = 1'b0;
         if (flag_clr[4]) m_upd = 1'b0;
         if (flag_clr[2]) m_f2 = 1'b0;
         if (m_run && m_pc == cfg.psc) begin
            m_pc = 0;
            wrap = cfg.dir_down ? (m_cnt == 0) : (m_cnt == cfg.arr[15:0]);
            if (wrap) m_cnt = cfg.dir_down ? cfg.arr[15:0] : 0;
            else m_cnt = cfg.dir_down ? m_cnt - 1 : m_cnt + 1;
            m_upd |= wrap;
            m_trig = wrap;
            if (m_cnt == ch_cfg[2].ccr[15:0]) begin
               m_o2 = !m_o2;
               m_f2 = 1'b1;
            end
         end else if (m_run) m_pc++;
         m_run = cfg.enable && (m_run || !m_en);
         m_en = cfg.enable;
      end
   end

   always @(negedge mclk) begin
      if (chk_on && m_run) begin
         check(count, m_cnt);
         check(upd_flag, m_upd);
         check(trig_out, m_trig);
         check(ch_out[2], m_o2);
         check(ch_flag[2], m_f2);
         check(ch_out[3], 1'b0);
         check(ch_out[1:0], {m_cnt >= ch_cfg[1].ccr[15:0], m_cnt < ch_cfg[0].ccr[15:0]});
      end
      for (int i = 0; i < 3; i++) begin
         st[i] = (ch_out[i] === ref_q[i]) ? st[i] + 1 : 0;
         ref_q[i] = ch_out[i];
         if (chk_on) check(pwm_hi[i] & pwm_lo[i], 1'b0);
         if (chk_on && st[i] > cfg.dead + 3)
            check({pwm_hi[i], pwm_lo[i]}, {ch_out[i], !ch_out[i]});
      end
   end

   // Generous span: the whole sequence needs about 1300 cycles
   initial begin
      #(25ns * 20000);
      errors++;
      test_done();
   end

   initial begin
      timer_pkg::timer_cfg_t c;
      timer_pkg::ch_cfg_t [3:0] k;
      int w;
      void'($urandom(32'h0C06));
      // Encoder first, while the shaft still rests at the reset position
      do_reset();
      c = '0;
      c.enable = 1'b1;
      c.cnt_mode = timer_pkg::CNT_ENCODER;
      c.arr = 32'h000003E8;
      cfg <= c;
      i_pins.quad(12, 1'b0);
      repeat (8) @(posedge mclk);
      check(count, 16'h000C);
      check(count_down, 1'b0);
      i_pins.jump();
      i_pins.jump();
      i_pins.quad(12, 1'b1);
      repeat (8) @(posedge mclk);
      check(count, 16'h0000);
      check(count_down, 1'b1);
      for (int d = 0; d < 2; d++) begin
         do_reset();
         c = '0;
         k = '0;
         c.enable = 1'b1;
         c.dir_down = d[0];
         c.psc = 16'($urandom_range(2, 0));
         c.arr = $urandom_range(12, 4);
         c.dead = 8'($urandom_range(5, 0));
         k[0].mode = timer_pkg::CH_PWM;
         k[0].ccr = $urandom_range(c.arr, 1);
         k[1] = k[0];
         k[1].invert = 1'b1;
         k[1].ccr = $urandom_range(c.arr, 1);
         k[2].mode = timer_pkg::CH_COMPARE;
         k[2].ccr = $urandom_range(c.arr, 0);
         cfg <= c;
         ch_cfg <= k;
         // Pairs are still in reset on the release edge; start looking one edge later
         @(posedge mclk);
         chk_on <= 1'b1;
         repeat (400) begin
            @(posedge mclk);
            flag_clr <= ($urandom_range(9, 0) == 0) ? 5'($urandom) : 5'h00;
         end
         @(posedge mclk);
         flag_clr <= 5'h00;
         chk_on <= 1'b0;
      end
      // Pulse width: rising capture on pin 3, falling capture of the same pin on channel 2
      do_reset();
      c = '0;
      k = '0;
      c.enable = 1'b1;
      c.arr = 32'h0000FFFF;
      k[3].mode = timer_pkg::CH_CAPTURE;
      k[2].mode = timer_pkg::CH_CAPTURE;
      k[2].cap_falling = 1'b1;
      k[2].cross_in = 1'b1;
      cfg <= c;
      ch_cfg <= k;
      repeat (20) @(posedge mclk);
      w = $urandom_range(40, 5);
      i_pins.pulse(3, w);
      repeat (12) @(posedge mclk);
      check(ch_flag[3:2], 2'h3);
      check(16'(cap_val[2] - cap_val[3]), w);
      flag_clr <= 5'h0C;
      @(posedge mclk);
      flag_clr <= 5'h00;
      repeat (2) @(posedge mclk);
      check(ch_flag[3:2], 2'h0);
      // Slave reset from the external trigger pin clears without an update
      do_reset();
      c.arr = 32'h000001F4;
      c.slave_mode = timer_pkg::SLV_RESET;
      cfg <= c;
      ch_cfg <= '0;
      repeat (60) @(posedge mclk);
      ext_trig <= 1'b1;
      repeat (2) @(posedge mclk);
      ext_trig <= 1'b0;
      repeat (6) @(posedge mclk);
      check(count < 16'h000C, 1'b1);
      check(upd_flag, 1'b0);
      // Gated by the chained trigger of another timer
      do_reset();
      c.slave_mode = timer_pkg::SLV_GATED;
      c.trig_chain = 1'b1;
      cfg <= c;
      repeat (30) @(posedge mclk);
      check(count, 16'h0000);
      chain_trig_in <= 1'b1;
      repeat (20) @(posedge mclk);
      chain_trig_in <= 1'b0;
      repeat (8) @(posedge mclk);
      check(count >= 16'h0011 && count <= 16'h0016, 1'b1);
      // One pulse: counter halts at its update, a trigger runs it again
      do_reset();
      c.slave_mode = timer_pkg::SLV_TRIGGER;
      c.trig_chain = 1'b0;
      c.arr = 32'h00000006;
      k = '0;
      k[0].mode = timer_pkg::CH_ONE_PULSE;
      k[0].ccr = 32'h00000003;
      cfg <= c;
      ch_cfg <= k;
      repeat (40) @(posedge mclk);
      check(count, 16'h0000);
      check(upd_flag, 1'b1);
      repeat (3) @(posedge mclk);
      check({count, ch_out[0]}, 17'h00000);
      ext_trig <= 1'b1;
      @(posedge mclk);
      ext_trig <= 1'b0;
      repeat (8) @(posedge mclk);
      check(count != 16'h0000, 1'b1);
      check(ch_out[0], 1'b1);
      // Center-aligned: up to the top, turn, down to zero, turn again
      do_reset();
      c.slave_mode = timer_pkg::SLV_OFF;
      c.cnt_mode = timer_pkg::CNT_CENTER;
      cfg <= c;
      ch_cfg <= '0;
      repeat (10) @(posedge mclk);
      check({count_down, count}, 17'h10004);
      repeat (6) @(posedge mclk);
      check({count_down, count, upd_flag}, 18'h00005);
      test_done();
   end
endmodule
